// ---- src/blld_core.sv ----
// Execute stage for load, AND and OR with two banks of sixteen registers.
`timescale 1ns/1ps
`default_nettype none
module blld_core
#(
  parameter int unsigned REG_COUNT = 16,
  parameter int unsigned DATA_WIDTH = 8
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [17:0] word_in,
  input wire logic word_valid_in,
  input wire logic bank_sel_in,
  input wire logic [3:0] peek_sel_in,
  output logic [7:0] peek_data_out,
  output logic zero_out,
  output logic carry_out,
  output logic wr_out,
  output logic [3:0] wr_sel_out,
  output logic [7:0] wr_data_out,
  output logic bank_out
);
  // The logic is written for the documented shape only.
  if (REG_COUNT != blld_pkg::REGS || DATA_WIDTH != blld_pkg::DATA_W)
  begin : g_bad_param
    $error("blld_core supports only 16 registers of 8 bits");
  end

  blld_pkg::blld_dec_t dec;
  blld_pkg::blld_flags_t flags;
  blld_pkg::blld_flags_t next_flags;
  logic [7:0] bank_a [REG_COUNT];
  logic [7:0] bank_b [REG_COUNT];
  logic [7:0] first_val;
  logic [7:0] second_val;
  logic [7:0] result;
  logic do_write;
  logic bank;
  logic next_bank;
  logic next_wr;
  logic [3:0] next_wr_sel;
  logic [7:0] next_wr_data;
  logic [7:0] next_peek;

  // Reads from the active bank; used for both operand fields and the peek.
  function automatic logic [7:0] blld_read(
    input logic [7:0] a [16],
    input logic [7:0] b [16],
    input logic which,
    input logic [3:0] sel
  );
    blld_read = which ? b[sel] : a[sel];
  endfunction

  blld_decode u_decode
  (
    .word_in(word_in),
    .word_valid_in(word_valid_in),
    .dec_out(dec)
  );

  // Operand fetch and the result of the decoded operation.
  always_comb
  begin
    first_val = blld_read(bank_a, bank_b, bank, dec.first_sel);
    second_val = dec.use_imm ? dec.immediate_byte :
      blld_read(bank_a, bank_b, bank, dec.second_sel);
    do_write = dec.valid && (dec.op != blld_pkg::BLLD_OP_NONE);
    next_flags = flags;
    case (dec.op)
      blld_pkg::BLLD_OP_LOAD: result = second_val;
      blld_pkg::BLLD_OP_AND: result = first_val & second_val;
      blld_pkg::BLLD_OP_OR: result = first_val | second_val;
      default: result = blld_pkg::DATA_ZERO;
    endcase
    if (dec.valid && (dec.op == blld_pkg::BLLD_OP_AND ||
      dec.op == blld_pkg::BLLD_OP_OR))
    begin
      next_flags.zero = (result == blld_pkg::DATA_ZERO);
      next_flags.carry = 1'b0;
    end
    // Bank changes take effect between instructions, never mid-write.
    next_bank = bank_sel_in;
    next_wr = do_write;
    next_wr_sel = dec.first_sel;
    next_wr_data = result;
    next_peek = blld_read(bank_a, bank_b, bank, peek_sel_in);
  end

  // Control state and registered outputs.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flags <= '{zero: blld_pkg::FLAG_RESET, carry: blld_pkg::FLAG_RESET};
      bank <= blld_pkg::BANK_RESET;
      wr_out <= 1'b0;
      wr_sel_out <= '0;
      wr_data_out <= blld_pkg::DATA_ZERO;
      peek_data_out <= blld_pkg::DATA_ZERO;
    end
    else
    begin
      flags <= next_flags;
      bank <= next_bank;
      wr_out <= next_wr;
      wr_sel_out <= next_wr_sel;
      wr_data_out <= next_wr_data;
      peek_data_out <= next_peek;
    end
  end

  // One write port per bank; a reset does not clear register contents.
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_regs
    always_ff @(posedge clk_in)
    begin
      if (do_write && dec.first_sel == 4'(i))
      begin
        if (bank)
          bank_b[i] <= result;
        else
          bank_a[i] <= result;
      end
    end

    // Each register takes the result when it is the destination.
    // write back first.
    a_reg_write: assert property (@(posedge clk_in)
      disable iff (rst_in)
      (do_write && dec.first_sel == 4'(i)) |=>
      (($past(bank) ? bank_b[i] : bank_a[i]) == $past(result)))
      else $error("register write-back lost");
  end

  assign zero_out = flags.zero;
  assign carry_out = flags.carry;
  assign bank_out = bank;

  // The checks below watch the registered outputs one cycle after the word
  // that caused them, the peek read-back two cycles after. Register contents
  // are never reset, so no check reads a register back unless a write to it
  // was seen first.

  // A zero AND result raises the zero flag, any other result clears it.
  // zero after AND.
  a_logic_zero: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_AND) |=>
    (zero_out == (wr_data_out == blld_pkg::DATA_ZERO)))
    else $error("zero flag wrong after AND");

  // The same zero test applies to an OR result.
  // zero after OR.
  a_or_zero: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_OR) |=>
    (zero_out == (wr_data_out == blld_pkg::DATA_ZERO)))
    else $error("zero flag wrong after OR");

  // Both logic operations leave the carry low whatever the operands.
  // carry cleared.
  a_logic_carry: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op inside {blld_pkg::BLLD_OP_AND,
    blld_pkg::BLLD_OP_OR}) |=> !carry_out)
    else $error("carry not cleared by logic op");

  // A load must not touch either flag.
  // load keeps flags.
  a_load_flags: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_LOAD) |=>
    $stable(zero_out) && $stable(carry_out))
    else $error("load changed a flag");

  // Only a logic operation may move the zero flag.
  // zero otherwise held.
  a_zero_hold: assert property (@(posedge clk_in)
    disable iff (rst_in)
    !(dec.valid && dec.op inside {blld_pkg::BLLD_OP_AND,
    blld_pkg::BLLD_OP_OR}) |=> $stable(zero_out))
    else $error("zero flag moved without a logic op");

  // Only a logic operation may move the carry flag.
  // carry otherwise held.
  a_carry_hold: assert property (@(posedge clk_in)
    disable iff (rst_in)
    !(dec.valid && dec.op inside {blld_pkg::BLLD_OP_AND,
    blld_pkg::BLLD_OP_OR}) |=> $stable(carry_out))
    else $error("carry flag moved without a logic op");

  // The immediate form of a load writes the immediate byte.
  // load immediate value.
  a_load_value: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_LOAD && dec.use_imm) |=>
    wr_out && wr_data_out == $past(dec.immediate_byte))
    else $error("load immediate not written");

  // The register form of a load copies the second operand register.
  // load register copy.
  a_load_copy: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_LOAD && !dec.use_imm) |=>
    wr_out && wr_data_out == $past(second_val))
    else $error("load copy not written");

  // No strobe follows a cycle without an executed word.
  // write only when executed.
  a_idle_strobe: assert property (@(posedge clk_in)
    disable iff (rst_in)
    !do_write |=> !wr_out)
    else $error("write strobe without a word");

  // AND combines both operands bit by bit.
  // bitwise AND.
  a_and_value: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_AND) |=>
    wr_data_out == ($past(first_val) & $past(second_val)))
    else $error("AND result wrong");

  // OR combines both operands bit by bit.
  // bitwise OR.
  a_or_value: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_OR) |=>
    wr_data_out == ($past(first_val) | $past(second_val)))
    else $error("OR result wrong");

  // The immediate AND takes its byte straight from the word.
  // immediate AND operand.
  a_and_imm: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_AND && dec.use_imm) |=>
    wr_data_out == ($past(first_val) &
    $past(word_in[blld_pkg::IMM_LSB +: blld_pkg::DATA_W])))
    else $error("AND immediate operand wrong");

  // The immediate OR takes its byte straight from the word.
  // immediate OR operand.
  a_or_imm: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_OR && dec.use_imm) |=>
    wr_data_out == ($past(first_val) |
    $past(word_in[blld_pkg::IMM_LSB +: blld_pkg::DATA_W])))
    else $error("OR immediate operand wrong");

  // An all-zero word rewrites register zero with its own value.
  // zero word loads.
  a_zero_word: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (word_valid_in && word_in == '0) |=>
    wr_out && wr_sel_out == '0 && wr_data_out == $past(first_val))
    else $error("zero word not a load of register zero");

  // The destination comes from the first register field.
  // first field position.
  a_write_sel: assert property (@(posedge clk_in)
    disable iff (rst_in)
    do_write |=> wr_sel_out ==
    $past(word_in[blld_pkg::FIRST_LSB +: blld_pkg::SEL_W]))
    else $error("destination field wrong");

  // The immediate byte comes from the low two digits of the word.
  // immediate field position.
  a_imm_field: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (dec.valid && dec.op == blld_pkg::BLLD_OP_LOAD && dec.use_imm) |=>
    wr_data_out == $past(word_in[blld_pkg::IMM_LSB +: blld_pkg::DATA_W]))
    else $error("immediate field wrong");

  // The active bank follows the select input one cycle later.
  // bank select follows.
  a_bank_follow: assert property (@(posedge clk_in)
    disable iff (rst_in)
    ##1 (bank_out == $past(bank_sel_in)))
    else $error("active bank did not follow select");

  // A value just written reads back from the same bank two cycles later.
  // read from active bank.
  a_bank_read: assert property (@(posedge clk_in)
    disable iff (rst_in)
    (do_write ##1 (peek_sel_in == $past(dec.first_sel) &&
    bank == $past(bank))) |=> peek_data_out == $past(result, 2))
    else $error("peek read from wrong bank");
endmodule // blld_core
`default_nettype wire

// ---- shared/blld_pkg.sv ----
// Shared constants and types for the byte load and logic decoder.
package blld_pkg;
  localparam int unsigned WORD_W = 18;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned REGS = 16;
  localparam int unsigned OPC_W = 6;
  // Bit positions of the instruction fields.
  localparam int unsigned OPC_LSB = 12;
  localparam int unsigned FIRST_LSB = 8;
  localparam int unsigned SECOND_LSB = 4;
  localparam int unsigned IMM_LSB = 0;
  // Opcode values of the decoded instructions.
  localparam logic [5:0] OPC_LOAD_REG = 6'h00;
  localparam logic [5:0] OPC_LOAD_IMM = 6'h01;
  localparam logic [5:0] OPC_AND_REG = 6'h02;
  localparam logic [5:0] OPC_AND_IMM = 6'h03;
  localparam logic [5:0] OPC_OR_REG = 6'h04;
  localparam logic [5:0] OPC_OR_IMM = 6'h05;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic BANK_RESET = 1'b0;

  typedef enum logic [1:0] {BLLD_OP_NONE, BLLD_OP_LOAD, BLLD_OP_AND,
    BLLD_OP_OR} blld_op_t;

  // Decoded view of one instruction word.
  typedef struct packed {
    logic valid;
    blld_op_t op;
    logic use_imm;
    logic [3:0] first_sel;
    logic [3:0] second_sel;
    logic [7:0] immediate_byte;
  } blld_dec_t;

  // Flags of the core.
  typedef struct packed {
    logic zero;
    logic carry;
  } blld_flags_t;
endpackage

// ---- src/blld_decode.sv ----
// Field extraction and opcode decoding of one instruction word.
`timescale 1ns/1ps
`default_nettype none
module blld_decode
(
  input wire logic [17:0] word_in,
  input wire logic word_valid_in,
  output blld_pkg::blld_dec_t dec_out
);
  logic [5:0] opcode;

  always_comb
  begin
    opcode = word_in[blld_pkg::OPC_LSB +: blld_pkg::OPC_W];
    dec_out.valid = word_valid_in;
    dec_out.first_sel = word_in[blld_pkg::FIRST_LSB +: blld_pkg::SEL_W];
    dec_out.second_sel = word_in[blld_pkg::SECOND_LSB +: blld_pkg::SEL_W];
    dec_out.immediate_byte = word_in[blld_pkg::IMM_LSB +: blld_pkg::DATA_W];
    dec_out.use_imm = opcode[0];
    case (opcode)
      blld_pkg::OPC_LOAD_REG,
      blld_pkg::OPC_LOAD_IMM: dec_out.op = blld_pkg::BLLD_OP_LOAD;
      blld_pkg::OPC_AND_REG,
      blld_pkg::OPC_AND_IMM: dec_out.op = blld_pkg::BLLD_OP_AND;
      blld_pkg::OPC_OR_REG,
      blld_pkg::OPC_OR_IMM: dec_out.op = blld_pkg::BLLD_OP_OR;
      default: dec_out.op = blld_pkg::BLLD_OP_NONE;
    endcase
  end
endmodule // blld_decode
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the byte load and logic decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [17:0] word_in = 18'h0_0000;
  logic word_valid_in = 1'b0;
  logic bank_sel_in = 1'b0;
  logic [3:0] peek_sel_in = 4'h0;
  logic [7:0] peek_data_out;
  logic zero_out;
  logic carry_out;
  logic wr_out;
  logic [3:0] wr_sel_out;
  logic [7:0] wr_data_out;
  logic bank_out;
  int num_errors = 0;
  int num_checks = 0;

  // Core clock at 100 MHz.
  always #5 clk_in = ~clk_in;

  blld_core dut_u (.clk_in(clk_in), .rst_in(rst_in), .word_in(word_in),
    .word_valid_in(word_valid_in), .bank_sel_in(bank_sel_in),
    .peek_sel_in(peek_sel_in), .peek_data_out(peek_data_out),
    .zero_out(zero_out), .carry_out(carry_out), .wr_out(wr_out),
    .wr_sel_out(wr_sel_out), .wr_data_out(wr_data_out),
    .bank_out(bank_out));

  // Compares one observed value with its expectation, counting both.
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Offers one word for a single edge; results are sampled 1 ns later.
  task automatic run(input logic [17:0] w);
    @(posedge clk_in);
    word_in <= w;
    word_valid_in <= 1'b1;
    @(posedge clk_in);
    word_valid_in <= 1'b0;
    #1;
  endtask

  // Checks the write strobe, destination, value and both flags.
  // Carry is never set by this block, so it is always expected low.
  task automatic res(input logic [3:0] sel, input logic [7:0] d,
    input logic z);
    chk("write strobe", {7'h00, wr_out}, 8'h01);
    chk("write select", {4'h0, wr_sel_out}, {4'h0, sel});
    chk("write data", wr_data_out, d);
    chk("zero flag", {7'h00, zero_out}, {7'h00, z});
    chk("carry flag", {7'h00, carry_out}, 8'h00);
  endtask

  // Reads one register of the active bank through the registered peek.
  task automatic peek(input logic [3:0] sel, input logic [7:0] exp);
    @(posedge clk_in);
    peek_sel_in <= sel;
    @(posedge clk_in);
    #1;
    chk("peek data", peek_data_out, exp);
  endtask

  // Switches bank and waits for the registered copy to take effect.
  task automatic bank(input logic b);
    @(posedge clk_in);
    bank_sel_in <= b;
    repeat (2) @(posedge clk_in);
    #1;
    chk("active bank", {7'h00, bank_out}, {7'h00, b});
  endtask

  // Loads at both ends of the register range, immediate then copy.
  task automatic t_load();
    run(18'h0_1F8E);
    res(4'hF, 8'h8E, 1'b0);
    run(18'h0_00F0);
    res(4'h0, 8'h8E, 1'b0);
    peek(4'h0, 8'h8E);
  endtask

  // AND in both forms; a zero result sets the flag, a load keeps it.
  task automatic t_and();
    run(18'h0_1ACA);
    run(18'h0_3A53);
    res(4'hA, 8'h42, 1'b0);
    run(18'h0_1ACA);
    run(18'h0_1B14);
    run(18'h0_2AB0);
    res(4'hA, 8'h00, 1'b1);
    run(18'h0_1C55);
    res(4'hC, 8'h55, 1'b1);
  endtask

  // OR in both forms; the zero flag clears and sets with the result.
  task automatic t_or();
    run(18'h0_1ACA);
    run(18'h0_5A53);
    res(4'hA, 8'hDB, 1'b0);
    run(18'h0_4AB0);
    res(4'hA, 8'hDF, 1'b0);
    run(18'h0_1100);
    run(18'h0_5100);
    res(4'h1, 8'h00, 1'b1);
  endtask

  // The all-zero word copies register zero onto itself, flags kept.
  task automatic t_null();
    run(18'h0_0000);
    res(4'h0, 8'h8E, 1'b1);
  endtask

  // A write in bank B leaves the same register of bank A untouched.
  task automatic t_bank();
    bank(1'b1);
    run(18'h0_103C);
    res(4'h0, 8'h3C, 1'b1);
    peek(4'h0, 8'h3C);
    bank(1'b0);
    peek(4'h0, 8'h8E);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: reset, reset values, then each scenario in turn.
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk("reset strobe", {7'h00, wr_out}, 8'h00);
    chk("reset flags", {6'h00, zero_out, carry_out}, 8'h00);
    t_load();
    t_and();
    t_or();
    t_null();
    t_bank();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
